// ===== core/ivr_defines.vh
/*
 * constants of the interrupt vector resolver: register byte offsets, fixed
 * vector addresses, relocatable entry numbers and special source codes.
 * assumes a 20-bit address space and a 32-bit register port.
 */
`ifndef IVR_DEFINES_VH
`define IVR_DEFINES_VH

// register byte offsets
`define IVR_REG_CTRL      8'h00
`define IVR_REG_VBASE     8'h04
`define IVR_REG_MATCH_EN  8'h08
`define IVR_REG_MATCH0    8'h0c
`define IVR_REG_MATCH1    8'h10
`define IVR_REG_MATCH2    8'h14
`define IVR_REG_MATCH3    8'h18
`define IVR_REG_LVL0      8'h1c
`define IVR_REG_LVL1      8'h20
`define IVR_REG_LVL2      8'h24
`define IVR_REG_LVL3      8'h28
`define IVR_REG_PEND      8'h2c
`define IVR_REG_STATUS    8'h30

// fixed vector table, low byte of each four-byte entry
`define IVR_VEC_UND       20'hfffdc
`define IVR_VEC_OVF       20'hfffe0
`define IVR_VEC_BRK       20'hfffe4
`define IVR_VEC_AMATCH    20'hfffe8
`define IVR_VEC_SSTEP     20'hfffec
`define IVR_VEC_WDT       20'hffff0
`define IVR_VEC_DBC       20'hffff4
`define IVR_VEC_NMI       20'hffff8
`define IVR_VEC_RESET     20'hffffc
`define IVR_FIX_LOW       20'hfffdc
`define IVR_FIX_HIGH      20'hfffff
`define IVR_VEC_BYTES     20'h00004
`define IVR_HI_BYTE_OFS   20'h00003
`define IVR_FIX_COUNT     4'h9
`define IVR_BRK_RELOC     8'hff

// relocatable table
`define IVR_TABLE_BYTES   9'h100
`define IVR_ENTRY_BRK     6'h00
`define IVR_ENTRY_FIRST   6'h04

// special source codes on src_o (bit 5 set marks a special)
`define IVR_SP_NMI        3'h0
`define IVR_SP_DBC        3'h1
`define IVR_SP_WDT        3'h2
`define IVR_SP_SSTEP      3'h3
`define IVR_SP_AMATCH     3'h4
`define IVR_SP_BRK        3'h5
`define IVR_SP_OVF        3'h6
`define IVR_SP_UND        3'h7
`define IVR_SP_FLAG       6'h20

`define IVR_LVL_W         3
`define IVR_LVL_PER_REG   8

`endif

// ===== core/ivr_top.v
/*
 * interrupt vector resolver: sorts special and peripheral requests, keeps
 * pending flags, picks one request and hands the cpu a vector address.
 * assumes the cpu core and peripherals run on clk_i, request pulses are one
 * cycle, and the cpu answers irq_o with a one-cycle ack_i.
 */
`timescale 1ns/1ns
`include "ivr_defines.vh"

module ivr_top #(
    parameter NSRC = 28,
    parameter AW   = 20
) (
    input  wire              clk_i,
    input  wire              reset_n_i,
    input  wire [7:0]        reg_addr_i,
    input  wire [31:0]       reg_wdata_i,
    input  wire              reg_we_i,
    input  wire              reg_re_i,
    output reg  [31:0]       reg_rdata_o,
    input  wire              global_en_i,
    input  wire [2:0]        processor_priority_level_i,
    input  wire [NSRC-1:0]   periph_req_i,
    input  wire [4:0]        alt_req_i,
    input  wire              nmi_n_i,
    input  wire              wdt_req_i,
    input  wire              debugger_break_source_i,
    input  wire              single_step_i,
    input  wire              undefined_opcode_instr_i,
    input  wire              overflow_check_i,
    input  wire              overflow_flag_i,
    input  wire              break_instr_i,
    input  wire [7:0]        brk_fixed_high_i,
    input  wire              instr_valid_i,
    input  wire [AW-1:0]     instr_addr_i,
    input  wire              ack_i,
    input  wire              id_check_req_i,
    output reg               irq_o,
    output reg  [AW-1:0]     vec_addr_o,
    output reg  [5:0]        src_o,
    output reg               fast_entry_o,
    output reg  [AW-1:0]     id_check_addr_o,
    output reg               id_check_busy_o
);

    localparam ST_IDLE = 1'b0;
    localparam ST_WAIT = 1'b1;

    // control and configuration registers
    reg  [4:0]            sel_r;
    reg  [AW-1:0]         vector_table_base_r;
    reg  [3:0]            match_enable_reg_r;
    reg  [AW-1:0]         match_addr_r [0:3];
    reg  [31:0]           lvl_r [0:3];
    reg  [NSRC-1:0]       request_pending_flag_r;
    reg  [7:0]            spec_r;
    reg                   state_r;
    reg                   cur_mask_r;
    reg  [5:0]            cur_idx_r;
    reg                   nmi_s1_r;
    reg                   nmi_s2_r;
    reg                   nmi_s3_r;
    reg  [3:0]            id_cnt_r;
    // loop indices, one per process so each keeps a single driver
    integer               i_hit;
    integer               i_sel;
    integer               i_lvl;
    integer               i_sp;
    integer               i_rst;

    // byte address of relocatable entry n: base plus four times the entry
    function [AW-1:0] reloc_addr;
        input [AW-1:0] base;
        input [5:0]    entry;
        begin
            reloc_addr = base + {{(AW-8){1'b0}}, entry, 2'b00};
        end
    endfunction

    // level words side by side; passed in, so the selector's sensitivity sees every write
    wire [127:0]          lvl_flat = {lvl_r[3], lvl_r[2], lvl_r[1], lvl_r[0]};

    // priority level field of maskable source k, one nibble per source
    function [2:0] lvl_of;
        input [127:0] flat;
        input [5:0]   k;
        begin
            lvl_of = flat[k[4:0]*4 +: `IVR_LVL_W];
        end
    endfunction

    // pin synchroniser, then edge detect on the second and third stages
    always @(posedge clk_i) begin
        if (!reset_n_i) begin
            nmi_s1_r <= 1'b1;
            nmi_s2_r <= 1'b1;
            nmi_s3_r <= 1'b1;
        end else begin
            nmi_s1_r <= nmi_n_i;
            nmi_s2_r <= nmi_s1_r;
            nmi_s3_r <= nmi_s2_r;
        end
    end

    // stages reset high, the pin's idle level, so leaving reset makes no false edge
    // falling pin edge
    wire nmi_fall = nmi_s3_r & ~nmi_s2_r;

    reg [3:0] match_hit;
    always @* begin
        for (i_hit = 0; i_hit < 4; i_hit = i_hit + 1)
            match_hit[i_hit] = instr_valid_i & match_enable_reg_r[i_hit] & (instr_addr_i == match_addr_r[i_hit]);
    end

    // shared entries pick their source by select bit
    reg [NSRC-1:0] req_eff;
    always @* begin
        req_eff = periph_req_i;
        for (i_sel = 0; i_sel < 5; i_sel = i_sel + 1)
            req_eff[i_sel+1] = sel_r[i_sel] ? alt_req_i[i_sel] : periph_req_i[i_sel+1];
    end
    // entries 6 and 7 share via sel_r[1] and sel_r[2]
    // entries 8 and 9 share via sel_r[3] and sel_r[4]
    // entries 10 to 12 are plain lines 6 to 8, no select

    // special events into one vector indexed by source code
    wire [7:0] spec_set = {undefined_opcode_instr_i,
                           overflow_check_i & overflow_flag_i,  // trap only with flag set
                           break_instr_i,
                           |match_hit,
                           single_step_i,
                           wdt_req_i,
                           debugger_break_source_i,
                           nmi_fall};

    // lowest entry number wins among equal levels, strict compare keeps first
    reg       best_hit;
    reg [5:0] best_idx;
    reg [2:0] best_lvl;
    always @* begin
        best_hit = 1'b0;
        best_idx = 6'h00;
        best_lvl = processor_priority_level_i;
        for (i_lvl = 0; i_lvl < NSRC; i_lvl = i_lvl + 1) begin
            // pending and level above processor level
            if (request_pending_flag_r[i_lvl] && lvl_of(lvl_flat, i_lvl[5:0]) > best_lvl) begin
                best_hit = 1'b1;
                best_idx = i_lvl[5:0];
                best_lvl = lvl_of(lvl_flat, i_lvl[5:0]);
            end
        end
        best_hit = best_hit & global_en_i;
    end

    // highest special wins; lowest code is most urgent
    reg       sp_hit;
    reg [2:0] sp_code;
    always @* begin
        sp_hit = 1'b0;
        sp_code = 3'h0;
        for (i_sp = 7; i_sp >= 0; i_sp = i_sp - 1) begin
            if (spec_r[i_sp]) begin
                sp_hit = 1'b1;
                sp_code = i_sp[2:0];
            end
        end
    end

    // vector address of the chosen special
    reg [AW-1:0] sp_vec;
    always @* begin
        case (sp_code)
            // every fixed entry in the top block
            `IVR_SP_NMI:    sp_vec = `IVR_VEC_NMI;
            `IVR_SP_DBC:    sp_vec = `IVR_VEC_DBC;
            `IVR_SP_WDT:    sp_vec = `IVR_VEC_WDT;
            `IVR_SP_SSTEP:  sp_vec = `IVR_VEC_SSTEP;
            `IVR_SP_AMATCH: sp_vec = `IVR_VEC_AMATCH;
            `IVR_SP_OVF:    sp_vec = `IVR_VEC_OVF;
            `IVR_SP_UND:    sp_vec = `IVR_VEC_UND;
            // ff in the fixed high byte redirects to relocatable entry 0
            `IVR_SP_BRK:    sp_vec = (brk_fixed_high_i == `IVR_BRK_RELOC) ?
                                     reloc_addr(vector_table_base_r, `IVR_ENTRY_BRK) : `IVR_VEC_BRK;
            default:        sp_vec = `IVR_VEC_RESET;
        endcase
    end

    wire accept = (state_r == ST_WAIT) & ack_i;

    // pending flags: hardware set wins over acceptance or software clear
    reg [NSRC-1:0] pend_clr;
    always @* begin
        pend_clr = {NSRC{1'b0}};
        if (accept && cur_mask_r)
            pend_clr[cur_idx_r[4:0]] = 1'b1;
        if (reg_we_i && reg_addr_i == `IVR_REG_PEND)
            pend_clr = pend_clr | ~reg_wdata_i[NSRC-1:0];
    end

    // set on request, clear on acceptance
    always @(posedge clk_i) begin
        if (!reset_n_i)
            request_pending_flag_r <= {NSRC{1'b0}};
        else
            request_pending_flag_r <= (request_pending_flag_r & ~pend_clr) | req_eff;
    end

    // special flags, cleared only by acceptance; a new event the same cycle is kept
    always @(posedge clk_i) begin
        if (!reset_n_i)
            spec_r <= 8'h00;
        else if (accept && !cur_mask_r)
            spec_r <= (spec_r & ~(8'h01 << cur_idx_r[2:0])) | spec_set;
        else
            spec_r <= spec_r | spec_set;
    end

    // request handshake toward the cpu; vector is latched and held until ack
    always @(posedge clk_i) begin
        if (!reset_n_i) begin
            state_r      <= ST_IDLE;
            irq_o        <= 1'b0;
            vec_addr_o   <= {AW{1'b0}};
            src_o        <= 6'h00;
            cur_mask_r   <= 1'b0;
            cur_idx_r    <= 6'h00;
            fast_entry_o <= 1'b0;
        end else begin
            case (state_r)
                ST_IDLE: begin
                    // specials bypass enable flag and levels
                    if (sp_hit) begin
                        state_r    <= ST_WAIT;
                        irq_o      <= 1'b1;
                        vec_addr_o <= sp_vec;
                        src_o      <= `IVR_SP_FLAG | {3'h0, sp_code};
                        cur_mask_r <= 1'b0;
                        cur_idx_r  <= {3'h0, sp_code};
                    // peripheral requests take the maskable path
                    end else if (best_hit) begin
                        state_r    <= ST_WAIT;
                        irq_o      <= 1'b1;
                        // maskable entries start at 4; 1 to 3 stay unused
                        vec_addr_o <= reloc_addr(vector_table_base_r, best_idx + `IVR_ENTRY_FIRST);
                        src_o      <= best_idx + `IVR_ENTRY_FIRST;
                        cur_mask_r <= 1'b1;
                        cur_idx_r  <= best_idx;
                    end
                    // even base allows the shorter entry sequence
                    fast_entry_o <= ~vector_table_base_r[0];
                end
                ST_WAIT: begin
                    // cpu fetches four bytes at vec_addr_o and branches
                    if (ack_i) begin
                        state_r <= ST_IDLE;
                        irq_o   <= 1'b0;
                    end
                end
                default: begin
                    state_r <= ST_IDLE;
                    irq_o   <= 1'b0;
                end
            endcase
        end
    end

    // walk the high byte of each fixed vector for the id check
    always @(posedge clk_i) begin
        if (!reset_n_i) begin
            id_cnt_r        <= 4'h0;
            id_check_busy_o <= 1'b0;
            id_check_addr_o <= `IVR_FIX_LOW + `IVR_HI_BYTE_OFS;
        end else if (id_check_busy_o) begin
            if (id_cnt_r == `IVR_FIX_COUNT - 4'h1) begin
                id_check_busy_o <= 1'b0;
                id_cnt_r        <= 4'h0;
                id_check_addr_o <= `IVR_FIX_LOW + `IVR_HI_BYTE_OFS;
            end else begin
                id_cnt_r        <= id_cnt_r + 4'h1;
                id_check_addr_o <= id_check_addr_o + `IVR_VEC_BYTES;
            end
        end else if (id_check_req_i) begin
            id_check_busy_o <= 1'b1;
        end
    end

    // register writes; pending flags handled above
    always @(posedge clk_i) begin
        if (!reset_n_i) begin
            sel_r               <= 5'h00;
            vector_table_base_r <= {AW{1'b0}};
            match_enable_reg_r  <= 4'h0;
            for (i_rst = 0; i_rst < 4; i_rst = i_rst + 1) begin
                match_addr_r[i_rst] <= {AW{1'b0}};
                lvl_r[i_rst]        <= 32'h0000_0000;
            end
        end else if (reg_we_i) begin
            case (reg_addr_i)
                `IVR_REG_CTRL:     sel_r               <= reg_wdata_i[4:0];
                // table of 256 bytes from this base
                `IVR_REG_VBASE:    vector_table_base_r <= reg_wdata_i[AW-1:0];
                `IVR_REG_MATCH_EN: match_enable_reg_r  <= reg_wdata_i[3:0];
                `IVR_REG_MATCH0:   match_addr_r[0]     <= reg_wdata_i[AW-1:0];
                `IVR_REG_MATCH1:   match_addr_r[1]     <= reg_wdata_i[AW-1:0];
                `IVR_REG_MATCH2:   match_addr_r[2]     <= reg_wdata_i[AW-1:0];
                `IVR_REG_MATCH3:   match_addr_r[3]     <= reg_wdata_i[AW-1:0];
                // level nibbles keep only their low three bits
                `IVR_REG_LVL0:     lvl_r[0]            <= reg_wdata_i & 32'h7777_7777;
                `IVR_REG_LVL1:     lvl_r[1]            <= reg_wdata_i & 32'h7777_7777;
                `IVR_REG_LVL2:     lvl_r[2]            <= reg_wdata_i & 32'h7777_7777;
                `IVR_REG_LVL3:     lvl_r[3]            <= reg_wdata_i & 32'h7777_7777;
                default: ;
            endcase
        end
    end

    // read data one cycle after the strobe, zero otherwise and for unmapped
    always @(posedge clk_i) begin
        if (!reset_n_i) begin
            reg_rdata_o <= 32'h0000_0000;
        end else if (reg_re_i) begin
            case (reg_addr_i)
                `IVR_REG_CTRL:     reg_rdata_o <= {27'h0, sel_r};
                `IVR_REG_VBASE:    reg_rdata_o <= {{(32-AW){1'b0}}, vector_table_base_r};
                `IVR_REG_MATCH_EN: reg_rdata_o <= {28'h0, match_enable_reg_r};
                `IVR_REG_MATCH0:   reg_rdata_o <= {{(32-AW){1'b0}}, match_addr_r[0]};
                `IVR_REG_MATCH1:   reg_rdata_o <= {{(32-AW){1'b0}}, match_addr_r[1]};
                `IVR_REG_MATCH2:   reg_rdata_o <= {{(32-AW){1'b0}}, match_addr_r[2]};
                `IVR_REG_MATCH3:   reg_rdata_o <= {{(32-AW){1'b0}}, match_addr_r[3]};
                `IVR_REG_LVL0:     reg_rdata_o <= lvl_r[0];
                `IVR_REG_LVL1:     reg_rdata_o <= lvl_r[1];
                `IVR_REG_LVL2:     reg_rdata_o <= lvl_r[2];
                `IVR_REG_LVL3:     reg_rdata_o <= lvl_r[3];
                `IVR_REG_PEND:     reg_rdata_o <= {{(32-NSRC){1'b0}}, request_pending_flag_r};
                `IVR_REG_STATUS:   reg_rdata_o <= {15'h0, spec_r, cur_mask_r, src_o, 1'b0, state_r};
                default:           reg_rdata_o <= 32'h0000_0000;
            endcase
        end else begin
            reg_rdata_o <= 32'h0000_0000;
        end
    end

endmodule // ivr_top

// ===== bench/ivr_checker.sv
/* checker for ivr_top: vector hold until ack, fixed vector map, nmi edge,
   mask gating, read port idle level and the id walk.
   assumes one clock domain and a one-cycle ack_i from the cpu. */
`timescale 1ns/1ns
module ivr_checker #(
    parameter AW = 20
) (
    input logic          clk_i,
    input logic          reset_n_i,
    input logic          reg_re_i,
    input logic [31:0]   reg_rdata_o,
    input logic          global_en_i,
    input logic          nmi_n_i,
    input logic [7:0]    brk_fixed_high_i,
    input logic          ack_i,
    input logic          irq_o,
    input logic [AW-1:0] vec_addr_o,
    input logic [5:0]    src_o,
    input logic [AW-1:0] id_check_addr_o,
    input logic          id_check_busy_o
);
    // one domain, so one clocking and one reset serve all properties
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!reset_n_i);
    logic [4:0] walk_cnt_r;

    // walk length counted here: nine is beyond a repetition count
    always @(posedge clk_i) begin
        if (!reset_n_i || !id_check_busy_o) begin
            walk_cnt_r <= 5'h00;
        end else begin
            walk_cnt_r <= walk_cnt_r + 5'h01;
        end
    end

    property p_irq_hold; irq_o && !ack_i |=> irq_o && $stable(vec_addr_o) && $stable(src_o); endproperty
    a_irq_hold: assert property (p_irq_hold) else $error("vector moved before ack");
    property p_irq_drop; irq_o && ack_i |=> !irq_o; endproperty
    a_irq_drop: assert property (p_irq_drop) else $error("irq still high after ack");
    property p_rd_idle; !reg_re_i |=> reg_rdata_o == 32'h0; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside its cycle");
    property p_fix_map;
        irq_o && src_o[5] && (src_o[2:0] != 3'h5 || brk_fixed_high_i != 8'hff)
            |-> vec_addr_o == 20'hffff8 - {15'h0, src_o[2:0], 2'b00};
    endproperty
    a_fix_map: assert property (p_fix_map) else $error("wrong fixed vector");
    property p_nmi_edge; $fell(nmi_n_i) |-> ##[2:60] (irq_o && src_o == 6'h20); endproperty
    a_nmi_edge: assert property (p_nmi_edge) else $error("pin edge not served");
    property p_mask_en; $rose(irq_o) && !src_o[5] |-> $past(global_en_i); endproperty
    a_mask_en: assert property (p_mask_en) else $error("maskable taken while disabled");
    property p_id_step;
        id_check_busy_o |-> id_check_addr_o == ($past(id_check_busy_o) ? $past(id_check_addr_o) + 20'h4 : 20'hfffdf);
    endproperty
    a_id_step: assert property (p_id_step) else $error("id walk address wrong");
    property p_id_len; $fell(id_check_busy_o) |-> walk_cnt_r == 5'h09; endproperty
    a_id_len: assert property (p_id_len) else $error("id walk length wrong");
endmodule // ivr_checker

bind ivr_top ivr_checker #(.AW(AW)) u_chk (.clk_i, .reset_n_i, .reg_re_i, .reg_rdata_o, .global_en_i, .nmi_n_i,
    .brk_fixed_high_i, .ack_i, .irq_o, .vec_addr_o, .src_o, .id_check_addr_o, .id_check_busy_o);

// ===== bench/ivr_cpu_model.sv
/* cpu core model: accepts an outstanding irq after delay_i cycles with a
   one-cycle ack. assumes irq_i holds until the edge that samples the ack. */
`timescale 1ns/1ns
module ivr_cpu_model (
    input  logic       clk_i,
    input  logic       reset_n_i,
    input  logic       irq_i,
    input  logic [5:0] src_i,
    input  logic [2:0] delay_i,
    output logic       ack_o,
    output logic       wdt_kick_o
);
    logic [2:0] wait_r;

    // ack only while irq is up; a long delay shows a slow core
    always @(posedge clk_i) begin
        ack_o <= 1'b0;
        wdt_kick_o <= 1'b0;
        if (!reset_n_i || ack_o) begin
            wait_r <= 3'h0;
        end else if (irq_i && wait_r == delay_i) begin
            ack_o <= 1'b1;
            wdt_kick_o <= (src_i == 6'h22);
        end else if (irq_i) begin
            wait_r <= wait_r + 3'h1;
        end
    end
endmodule // ivr_cpu_model

// ===== bench/test_ivr.sv
/* bench for ivr_top: drives registers and requests, keeps expected vectors
   in a queue, compares each accepted one. assumes the cpu model acks. */
`timescale 1ns/1ns
module test_ivr;
    logic        clk_i = 1'b0, reset_n_i = 1'b0, reg_we_i = 1'b0, reg_re_i = 1'b0;
    logic        global_en_i = 1'b0, nmi_n_i = 1'b1, overflow_flag_i = 1'b0;
    logic        instr_valid_i = 1'b0, id_check_req_i = 1'b0;
    logic [7:0]  reg_addr_i = 8'h00, brk_fixed_high_i = 8'h00, sp = 8'h00;
    logic [31:0] reg_wdata_i = 32'h0;
    logic [2:0]  processor_priority_level_i = 3'h2, delay_r = 3'h0;
    logic [27:0] periph_req_i = 28'h0;
    logic [4:0]  alt_req_i = 5'h0;
    logic [19:0] instr_addr_i = 20'h0, base_r;
    logic [15:0] seed = 16'h0050;
    wire         ack_i, irq_o, fast_entry_o, id_check_busy_o;
    wire [31:0]  reg_rdata_o;
    wire [19:0]  vec_addr_o, id_check_addr_o;
    wire [5:0]   src_o;
    logic [25:0] exp_q[$];
    int          n_mismatch = 0;
    int          compares = 0;
    int          k;

    ivr_top u_dut (.clk_i, .reset_n_i, .reg_addr_i, .reg_wdata_i, .reg_we_i, .reg_re_i, .reg_rdata_o,
        .global_en_i, .processor_priority_level_i, .periph_req_i, .alt_req_i, .nmi_n_i, .wdt_req_i(sp[2]),
        .debugger_break_source_i(sp[1]), .single_step_i(sp[3]), .undefined_opcode_instr_i(sp[7]),
        .overflow_check_i(sp[6]), .overflow_flag_i, .break_instr_i(sp[5]), .brk_fixed_high_i, .instr_valid_i,
        .instr_addr_i, .ack_i, .id_check_req_i, .irq_o, .vec_addr_o, .src_o, .fast_entry_o, .id_check_addr_o,
        .id_check_busy_o);
    ivr_cpu_model u_cpu (.clk_i, .reset_n_i, .irq_i(irq_o), .src_i(src_o), .delay_i(delay_r), .ack_o(ack_i),
        .wdt_kick_o());

    // 50 ns clock
    initial begin
        forever #25 clk_i = ~clk_i;
    end

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    // expected vector of a relocatable entry and of a special code
    function automatic logic [25:0] ent(input int e);
        return {base_r + 20'(4 * e), 6'(e)};
    endfunction
    function automatic logic [25:0] spv(input int c);
        return {20'hffff8 - 20'(4 * c), 6'h20 | 6'(c)};
    endfunction

    task chk_val(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t value %h expected %h", $time, got, exp);
        end
    endtask
    task chk_vec(input logic [25:0] got, input logic [25:0] exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t vector %h expected %h", $time, got, exp);
        end
    endtask

    // each accepted vector against the oldest expected; none expected gives 0
    always @(posedge clk_i) begin
        if (reset_n_i === 1'b1 && irq_o === 1'b1 && ack_i === 1'b1) begin
            chk_vec({vec_addr_o, src_o}, exp_q.size() ? exp_q.pop_front() : 26'h0);
        end
    end

    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_we_i <= 1'b1;
        @(posedge clk_i);
        reg_we_i <= 1'b0;
    endtask
    task rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk_i);
        reg_addr_i <= a;
        reg_re_i <= 1'b1;
        @(posedge clk_i);
        reg_re_i <= 1'b0;
        // read data stand only in this cycle; look mid-cycle, then resync to the edge
        @(negedge clk_i);
        chk_val(reg_rdata_o, e);
        @(posedge clk_i);
    endtask
    // one-cycle request pulses; a fresh random ack delay each time
    task pulse(input logic [27:0] p, input logic [4:0] a, input logic [7:0] s);
        @(posedge clk_i);
        seed = lfsr(seed);
        delay_r <= seed[2:0];
        periph_req_i <= p;
        alt_req_i <= a;
        sp <= s;
        @(posedge clk_i);
        periph_req_i <= 28'h0;
        alt_req_i <= 5'h0;
        sp <= 8'h00;
    endtask
    // wait for all expected vectors, then a quiet spell to catch strays
    task drain;
        int n;
        n = 0;
        while ((exp_q.size() != 0 || irq_o !== 1'b0) && n < 300) begin
            @(posedge clk_i);
            n++;
        end
        chk_val(exp_q.size(), 0);
        chk_val(n < 300, 1);
        repeat (12) @(posedge clk_i);
    endtask
    task fetch(input logic [19:0] a);
        @(posedge clk_i);
        instr_valid_i <= 1'b1;
        instr_addr_i <= a;
        @(posedge clk_i);
        instr_valid_i <= 1'b0;
        drain;
    endtask

    task report_and_stop;
        if (n_mismatch == 0 && compares > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    // cut a hang short far beyond the roughly 1100 cycles of the run
    initial begin
        #(50 * 20000);
        n_mismatch++;
        report_and_stop;
    end

    initial begin
        repeat (8) @(posedge clk_i);
        reset_n_i <= 1'b1;
        rd(8'h04, 32'h0);
        rd(8'h40, 32'h0);
        seed = lfsr(seed);
        base_r = {seed, 4'h0};
        wr(8'h04, {12'h0, base_r});
        rd(8'h04, {12'h0, base_r});
        for (k = 0; k < 4; k++) begin
            wr(8'h1c + 8'(4 * k), 32'h33333333);
        end
        wr(8'h28, 32'hbbbbbbbb);
        rd(8'h28, 32'h33333333);
        global_en_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        chk_val(fast_entry_o, 1);
        // every peripheral line, then the alternate sources of entries 5 to 9
        for (k = 0; k < 28; k++) begin
            exp_q.push_back(ent(k + 4));
            pulse(28'h1 << k, 5'h0, 8'h00);
            drain;
        end
        wr(8'h00, 32'h1f);
        for (k = 0; k < 5; k++) begin
            exp_q.push_back(ent(k + 5));
            pulse(28'h0, 5'h1 << k, 8'h00);
            drain;
        end
        pulse(28'h2, 5'h0, 8'h00);
        drain;
        wr(8'h00, 32'h0);
        // blocked by the flag, then by level, then a tie at one level
        global_en_i <= 1'b0;
        pulse(28'h208, 5'h0, 8'h00);
        repeat (8) @(posedge clk_i);
        chk_val(irq_o, 0);
        global_en_i <= 1'b1;
        processor_priority_level_i <= 3'h3;
        repeat (8) @(posedge clk_i);
        chk_val(irq_o, 0);
        exp_q.push_back(ent(7));
        exp_q.push_back(ent(13));
        processor_priority_level_i <= 3'h2;
        drain;
        // pending flag set, then cleared by software before it is taken
        global_en_i <= 1'b0;
        pulse(28'h1, 5'h0, 8'h00);
        rd(8'h2c, 32'h1);
        wr(8'h2c, 32'hfffffffe);
        rd(8'h2c, 32'h0);
        global_en_i <= 1'b1;
        drain;
        // specials with the global flag off; ovf only with the flag set
        // debug-tool sources are pulsed only here, to map their entries
        global_en_i <= 1'b0;
        overflow_flag_i <= 1'b1;
        brk_fixed_high_i <= 8'h12;
        for (k = 1; k < 8; k++) begin
            if (k == 4) continue;
            exp_q.push_back(spv(k));
            pulse(28'h0, 5'h0, 8'h1 << k);
            drain;
        end
        overflow_flag_i <= 1'b0;
        pulse(28'h0, 5'h0, 8'h40);
        drain;
        brk_fixed_high_i <= 8'hff;
        exp_q.push_back({base_r, 6'h25});
        pulse(28'h0, 5'h0, 8'h20);
        drain;
        // a special wins over a maskable request of the same cycle
        global_en_i <= 1'b1;
        exp_q.push_back(spv(2));
        exp_q.push_back(ent(4));
        pulse(28'h1, 5'h0, 8'h04);
        drain;
        // the falling pin edge alone raises the interrupt
        exp_q.push_back(spv(0));
        nmi_n_i <= 1'b0;
        drain;
        nmi_n_i <= 1'b1;
        drain;
        // last match register, with and without its enable bit
        wr(8'h18, {12'h0, seed, 4'h5});
        wr(8'h08, 32'h8);
        exp_q.push_back(spv(4));
        fetch({seed, 4'h5});
        wr(8'h08, 32'h0);
        fetch({seed, 4'h5});
        wr(8'h04, {12'h0, base_r | 20'h1});
        repeat (3) @(posedge clk_i);
        chk_val(fast_entry_o, 0);
        // id walk, then a second reset in mid-run
        id_check_req_i <= 1'b1;
        @(posedge clk_i);
        id_check_req_i <= 1'b0;
        // nine high-byte addresses, one per cycle, looked at mid-cycle
        for (k = 0; k < 9; k++) begin
            @(negedge clk_i);
            chk_val({12'h0, id_check_addr_o}, 32'hfffdf + 32'(4 * k));
        end
        repeat (5) @(posedge clk_i);
        chk_val(id_check_busy_o, 0);
        reset_n_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        reset_n_i <= 1'b1;
        rd(8'h04, 32'h0);
        report_and_stop;
    end
endmodule // test_ivr
